// [design/host_port_pkg.sv]
// package: register map, field positions and carrier types of the host port control block
package host_port_pkg;

    // =====================================================================
    // register map (wishbone byte addresses, one word each)
    // =====================================================================
    localparam logic [3:0] core_ctrl_addr = 4'h0;
    localparam logic [3:0] pin_cfg_addr = 4'h4;
    localparam logic [3:0] host_state_addr = 4'h8;
    localparam logic [3:0] pin_state_addr = 4'hc;

    localparam logic [7:0] core_ctrl_reset = 8'h00;
    localparam logic [15:0] pin_cfg_reset = 16'h0000;

    // =====================================================================
    // core side control fields
    // =====================================================================
    localparam int ctrl_rx_irq_en_bit = 0;
    localparam int ctrl_tx_irq_en_bit = 1;
    localparam int ctrl_cmd_irq_en_bit = 2;
    localparam int ctrl_flag2_bit = 3;
    localparam int ctrl_flag3_bit = 4;
    localparam int ctrl_dma_lsb = 5;
    localparam int ctrl_dma_msb = 7;

    typedef enum logic [2:0] {
        dma_off = 3'h0,
        dma_h2c_24 = 3'h1,
        dma_h2c_16 = 3'h2,
        dma_h2c_8 = 3'h3,
        dma_host_width = 3'h4,
        dma_c2h_24 = 3'h5,
        dma_c2h_16 = 3'h6,
        dma_c2h_8 = 3'h7
    } dma_mode_t;

    // =====================================================================
    // pin configuration fields
    // =====================================================================
    localparam int cfg_gpio_en_bit = 0;
    localparam int cfg_addr8_en_bit = 1;
    localparam int cfg_addr9_en_bit = 2;
    localparam int cfg_select_en_bit = 3;
    localparam int cfg_req_en_bit = 4;
    localparam int cfg_ack_en_bit = 5;
    localparam int cfg_port_en_bit = 6;
    localparam int cfg_req_od_bit = 8;
    localparam int cfg_strobe_pol_bit = 9;
    localparam int cfg_as_pol_bit = 10;
    localparam int cfg_mux_bit = 11;
    localparam int cfg_dual_strobe_bit = 12;
    localparam int cfg_select_pol_bit = 13;
    localparam int cfg_req_pol_bit = 14;
    localparam int cfg_ack_pol_bit = 15;

    // pin index of the eight shared pins in the pin vectors
    localparam int pin_addr8 = 0;
    localparam int pin_addr9 = 1;
    localparam int pin_select = 2;
    localparam int pin_req = 3;
    localparam int pin_ack = 4;
    localparam int pin_as = 5;
    localparam int pin_ds = 6;
    localparam int pin_rw = 7;
    localparam int pin_count = 8;

    // =====================================================================
    // carrier types
    // =====================================================================
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    // host-function strobes after polarity correction, active high; rw_dir is the raw pin level
    typedef struct packed {
        logic select;
        logic addr_strobe;
        logic data_strobe;
        logic read_strobe;
        logic write_strobe;
        logic acknowledge;
        logic rw_dir;
    } host_strobes_t;

    // core-side events from the data path
    typedef struct packed {
        logic rx_full;
        logic tx_empty;
        logic cmd_pending;
    } core_events_t;

    typedef struct packed {
        logic rx_irq;
        logic tx_irq;
        logic cmd_irq;
    } core_irqs_t;

    // request demands from the data path, active high
    typedef struct packed {
        logic host_req;
        logic tx_req;
        logic rx_req;
    } host_reqs_t;

endpackage

// [design/host_port_ctrl.sv]
// module: core side control and pin configuration of the parallel host port
// Behaviour
// - port disabled makes every pin gpio
// - gpio enable connects or disconnects gpio pins
// - addr8 pin enable, forced by mux, port
// - addr9 pin enable, forced by mux, port
// - select pin enable, zero when port off
// - request pins enable, both request pins
// - acknowledge enable, ignored under double request
// - request lines driven or open drain
// - data strobes polarity low or high
// - address strobe polarity low or high
// - separate or multiplexed address/data bus
// - single strobe or dual read/write strobes
// - chip select polarity low or high
// - request output and acknowledge input polarities
// - receive and transmit interrupt enables
// - command interrupt enable
// - dma off, host width, host-to-core widths
// - core-to-host dma widths
//
// Added by the designer: the Wishbone register port and the address map.
module host_port_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic soft_rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // data path side
    input wire host_port_pkg::core_events_t events_i,
    input wire host_port_pkg::host_reqs_t reqs_i,
    input wire logic double_request_select_i,
    output host_port_pkg::core_irqs_t irqs_o,
    output logic core_flag_2_o,
    output logic core_flag_3_o,
    output logic [2:0] dma_mode_o,
    output logic dma_enable_o,
    output logic dma_core_to_host_o,
    output logic [1:0] dma_width_o,
    output logic muxed_bus_o,
    output logic dual_strobe_o,
    output logic port_enable_o,
    output host_port_pkg::host_strobes_t strobes_o,
    // shared pins
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] host_fn_o,
    // general purpose side of the pins
    input wire logic [7:0] gpio_out_i,
    input wire logic [7:0] gpio_dir_i,
    output logic [7:0] gpio_in_o
);

    // =====================================================================
    // register state
    // =====================================================================
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic ack_q;
    logic ack_d;
    logic err_q;
    logic err_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    host_port_pkg::core_irqs_t irqs_q;
    host_port_pkg::core_irqs_t irqs_d;
    host_port_pkg::host_strobes_t strobes_q;
    host_port_pkg::host_strobes_t strobes_d;

    // merge written bytes into a register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return r;
    endfunction

    // undo a programmable polarity: result is active high
    function automatic logic polar(input logic level, input logic active_high);
        return active_high ? level : ~level;
    endfunction

    // =====================================================================
    // effective configuration
    // =====================================================================
    logic port_en;
    logic gpio_en;
    logic mux_eff;
    logic dual_eff;
    logic en_addr8;
    logic en_addr9;
    logic en_select;
    logic en_req;
    logic en_ack;
    logic req_od;
    logic req_pol;
    logic strobe_pol;
    logic [7:0] host_fn;

    always_comb begin
        port_en = cfg_q[host_port_pkg::cfg_port_en_bit];
        gpio_en = cfg_q[host_port_pkg::cfg_gpio_en_bit];
        // bus format bits only count while the port is on
        mux_eff = port_en & cfg_q[host_port_pkg::cfg_mux_bit];
        dual_eff = port_en & cfg_q[host_port_pkg::cfg_dual_strobe_bit];
        // separate bus needs the high address pins, so they are forced on
        en_addr8 = port_en & (~mux_eff | cfg_q[host_port_pkg::cfg_addr8_en_bit]);
        en_addr9 = port_en & (~mux_eff | cfg_q[host_port_pkg::cfg_addr9_en_bit]);
        en_select = port_en & cfg_q[host_port_pkg::cfg_select_en_bit];
        en_req = port_en & cfg_q[host_port_pkg::cfg_req_en_bit];
        // double request takes the ack pin as a second request line
        en_ack = en_req & (double_request_select_i | cfg_q[host_port_pkg::cfg_ack_en_bit]);
        req_od = port_en & cfg_q[host_port_pkg::cfg_req_od_bit];
        req_pol = port_en & cfg_q[host_port_pkg::cfg_req_pol_bit];
        strobe_pol = port_en & cfg_q[host_port_pkg::cfg_strobe_pol_bit];
        host_fn = 8'h00;
        host_fn[host_port_pkg::pin_addr8] = en_addr8;
        host_fn[host_port_pkg::pin_addr9] = en_addr9;
        host_fn[host_port_pkg::pin_select] = en_select;
        host_fn[host_port_pkg::pin_req] = en_req;
        host_fn[host_port_pkg::pin_ack] = en_ack;
        host_fn[host_port_pkg::pin_as] = mux_eff;
        host_fn[host_port_pkg::pin_ds] = port_en;
        host_fn[host_port_pkg::pin_rw] = port_en;
        if (!port_en) begin
            host_fn = 8'h00;
        end
    end

    // =====================================================================
    // pin drive
    // =====================================================================
    logic req_level;
    logic ack_level;

    always_comb begin
        req_level = double_request_select_i ? reqs_i.tx_req : reqs_i.host_req;
        ack_level = reqs_i.rx_req;
        for (int i = 0; i < host_port_pkg::pin_count; i++) begin
            // disconnected gpio pins neither drive nor pass input
            pin_o[i] = gpio_en & gpio_out_i[i];
            pin_oe_o[i] = gpio_en & gpio_dir_i[i];
            if (host_fn[i]) begin
                pin_o[i] = 1'b0;
                pin_oe_o[i] = 1'b0;
            end
        end
        if (host_fn[host_port_pkg::pin_req]) begin
            // open drain only pulls the line low and releases it at the high level
            pin_o[host_port_pkg::pin_req] = ~(req_level ^ req_pol);
            pin_oe_o[host_port_pkg::pin_req] = req_od
                ? pin_o[host_port_pkg::pin_req] == 1'b0 : 1'b1;
        end
        if (host_fn[host_port_pkg::pin_ack] && double_request_select_i) begin
            pin_o[host_port_pkg::pin_ack] = ~(ack_level ^ req_pol);
            pin_oe_o[host_port_pkg::pin_ack] = req_od
                ? pin_o[host_port_pkg::pin_ack] == 1'b0 : 1'b1;
        end
    end

    // =====================================================================
    // pin input synchroniser and decoding
    // =====================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else if (ce_i) begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    always_comb begin
        gpio_in_o = pin_s2_q & ~host_fn & {8{gpio_en}};
        strobes_d = '0;
        if (port_en) begin
            strobes_d.select = en_select & polar(pin_s2_q[host_port_pkg::pin_select],
                cfg_q[host_port_pkg::cfg_select_pol_bit]);
            strobes_d.addr_strobe = mux_eff & polar(pin_s2_q[host_port_pkg::pin_as],
                cfg_q[host_port_pkg::cfg_as_pol_bit]);
            strobes_d.acknowledge = en_ack & ~double_request_select_i
                & polar(pin_s2_q[host_port_pkg::pin_ack],
                cfg_q[host_port_pkg::cfg_ack_pol_bit]);
            if (dual_eff) begin
                strobes_d.write_strobe = polar(pin_s2_q[host_port_pkg::pin_ds],
                    strobe_pol);
                strobes_d.read_strobe = polar(pin_s2_q[host_port_pkg::pin_rw],
                    strobe_pol);
            end else begin
                strobes_d.data_strobe = polar(pin_s2_q[host_port_pkg::pin_ds],
                    strobe_pol);
                strobes_d.rw_dir = pin_s2_q[host_port_pkg::pin_rw];
            end
        end
    end

    // =====================================================================
    // core interrupts and dma decode
    // =====================================================================
    always_comb begin
        irqs_d.rx_irq = events_i.rx_full & ctrl_q[host_port_pkg::ctrl_rx_irq_en_bit];
        irqs_d.tx_irq = events_i.tx_empty & ctrl_q[host_port_pkg::ctrl_tx_irq_en_bit];
        irqs_d.cmd_irq = events_i.cmd_pending
            & ctrl_q[host_port_pkg::ctrl_cmd_irq_en_bit];
    end

    host_port_pkg::dma_mode_t dma_mode;
    always_comb begin
        dma_mode = host_port_pkg::dma_mode_t'(ctrl_q[host_port_pkg::ctrl_dma_msb:
            host_port_pkg::ctrl_dma_lsb]);
        dma_enable_o = dma_mode != host_port_pkg::dma_off;
        dma_core_to_host_o = 1'b0;
        dma_width_o = 2'h0;
        unique case (dma_mode)
            host_port_pkg::dma_off, host_port_pkg::dma_host_width: begin
                dma_width_o = 2'h0;
            end
            host_port_pkg::dma_h2c_24, host_port_pkg::dma_h2c_16,
            host_port_pkg::dma_h2c_8: begin
                dma_width_o = dma_mode[1:0];
            end
            host_port_pkg::dma_c2h_24, host_port_pkg::dma_c2h_16,
            host_port_pkg::dma_c2h_8: begin
                dma_core_to_host_o = 1'b1;
                dma_width_o = dma_mode[1:0];
            end
        endcase
    end

    assign dma_mode_o = ctrl_q[host_port_pkg::ctrl_dma_msb:host_port_pkg::ctrl_dma_lsb];
    assign core_flag_2_o = ctrl_q[host_port_pkg::ctrl_flag2_bit];
    assign core_flag_3_o = ctrl_q[host_port_pkg::ctrl_flag3_bit];
    assign muxed_bus_o = mux_eff;
    assign dual_strobe_o = dual_eff;
    assign port_enable_o = port_en;
    assign host_fn_o = host_fn;
    assign irqs_o = irqs_q;
    assign strobes_o = strobes_q;

    // =====================================================================
    // wishbone slave: one wait state, ack for one cycle
    // =====================================================================
    logic req;
    logic [31:0] ctrl_img;
    logic [31:0] cfg_img;

    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
        ctrl_img = merge({24'h000000, ctrl_q}, wb_dat_i, wb_sel_i);
        cfg_img = merge({16'h0000, cfg_q}, wb_dat_i, wb_sel_i);
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        rdat_d = 32'h00000000;
        if (req) begin
            unique case (wb_adr_i)
                host_port_pkg::core_ctrl_addr: begin
                    ack_d = 1'b1;
                    rdat_d = {24'h000000, ctrl_q};
                    if (wb_we_i) begin
                        ctrl_d = ctrl_img[7:0];
                    end
                end
                host_port_pkg::pin_cfg_addr: begin
                    ack_d = 1'b1;
                    rdat_d = {16'h0000, cfg_q};
                    if (wb_we_i) begin
                        cfg_d = cfg_img[15:0];
                    end
                end
                host_port_pkg::host_state_addr: begin
                    ack_d = 1'b1;
                    rdat_d = {24'h000000, 1'b0, strobes_q};
                end
                host_port_pkg::pin_state_addr: begin
                    ack_d = 1'b1;
                    rdat_d = {16'h0000, host_fn, gpio_in_o};
                end
                default: begin
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            ctrl_q <= host_port_pkg::core_ctrl_reset;
            cfg_q <= host_port_pkg::pin_cfg_reset;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h00000000;
            irqs_q <= '0;
            strobes_q <= '0;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
            irqs_q <= irqs_d;
            strobes_q <= strobes_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

endmodule

// [verif/host_port_ctrl_assertions.sv]
// checker: bus answer, interrupt causes, mode decode and pin ownership
module host_port_ctrl_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire host_port_pkg::core_events_t events_i,
    input wire host_port_pkg::core_irqs_t irqs_o,
    input wire logic core_flag_2_o,
    input wire logic [2:0] dma_mode_o,
    input wire logic dma_enable_o,
    input wire logic dma_core_to_host_o,
    input wire logic [1:0] dma_width_o,
    input wire logic muxed_bus_o,
    input wire logic dual_strobe_o,
    input wire logic port_enable_o,
    input wire logic [7:0] host_fn_o
);
    // =====================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || soft_rst_i);
    sequence wb_take;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    endsequence
    // one answer, gone again the cycle after
    sequence wb_answer;
        (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    chk_bus_answer: assert property (wb_take |=> wb_answer)
        else $error("bus request not answered in one cycle");
    chk_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_rx_irq_cause: assert property ($rose(irqs_o.rx_irq) |-> $past(events_i.rx_full))
        else $error("rx irq without rx event");
    chk_tx_irq_cause: assert property ($rose(irqs_o.tx_irq) |-> $past(events_i.tx_empty))
        else $error("tx irq without tx event");
    chk_cmd_irq_cause: assert property ($rose(irqs_o.cmd_irq) |-> $past(events_i.cmd_pending))
        else $error("cmd irq without command");
    chk_dma_decode: assert property (dma_enable_o == (dma_mode_o != 3'h0) && dma_width_o == dma_mode_o[1:0])
        else $error("dma enable or width decode wrong");
    chk_dma_direction: assert property (dma_core_to_host_o == (dma_mode_o[2] && dma_mode_o[1:0] != 2'h0))
        else $error("dma direction decode wrong");
    chk_port_off_gpio: assert property (!port_enable_o |-> host_fn_o == 8'h00 && !muxed_bus_o && !dual_strobe_o)
        else $error("host function while port off");
    chk_sep_bus_addr: assert property (port_enable_o && !muxed_bus_o |-> host_fn_o[1:0] == 2'h3)
        else $error("address pins not forced on separate bus");
    chk_reset_clears: assert property (($past(rst_i) || $past(soft_rst_i)) |-> dma_mode_o == 3'h0 && !core_flag_2_o && !port_enable_o)
        else $error("state not cleared by reset");
endmodule

bind host_port_ctrl host_port_ctrl_assertions host_port_ctrl_assertions_i (.clk_i, .rst_i,
    .soft_rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .events_i, .irqs_o,
    .core_flag_2_o, .dma_mode_o, .dma_enable_o, .dma_core_to_host_o, .dma_width_o,
    .muxed_bus_o, .dual_strobe_o, .port_enable_o, .host_fn_o);

// [verif/host_bus_model.sv]
// host model: drives host pins in the configured style and polarity
module host_bus_model (
    input wire logic dual_i,
    input wire logic strobe_pol_i,
    input wire logic as_pol_i,
    input wire logic select_pol_i,
    input wire logic ack_pol_i,
    input wire logic drq_i,
    input wire logic [4:0] act_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    output logic [7:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================
    // pin levels, act_i is select, as, read, write, ack
    logic [7:0] drv;
    always_comb begin
        drv[1:0] = addr_i;
        drv[2] = act_i[4] ~^ select_pol_i;
        drv[3] = 1'b1;
        drv[4] = drq_i ? 1'b1 : (act_i[0] ~^ ack_pol_i);
        drv[5] = act_i[3] ~^ as_pol_i;
        drv[6] = (dual_i ? act_i[1] : (act_i[2] | act_i[1])) ~^ strobe_pol_i;
        drv[7] = dual_i ? (act_i[2] ~^ strobe_pol_i) : act_i[2];
        // released request lines sit on their pull-up
        for (int k = 0; k < 8; k++)
            pin_i[k] = pin_oe_o[k] ? pin_o[k] : drv[k];
    end
endmodule

// [verif/host_port_ctrl_tb.sv]
// testbench: registers, dma decode, interrupts and pin muxing of the host port control
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module host_port_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] ctrl_a = host_port_pkg::core_ctrl_addr;
    localparam logic [3:0] cfg_a = host_port_pkg::pin_cfg_addr;
    logic clk_i = 0, rst_i = 1, soft_rst_i = 0, cyc = 0, we = 0, drq = 0, errb;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o, seed_v;
    logic ack_o, err_o, c2h, dma_en, mux_o, dual_o, port_o, f2, f3;
    logic [1:0] width_o, addr = 2'h0;
    logic [2:0] mode_o;
    logic [4:0] act = 5'h0;
    logic [7:0] pin_i, pin_o, oe_o, fn_o, gout = 8'h0, gdir = 8'h0, gin_o;
    host_port_pkg::core_events_t ev = '0;
    host_port_pkg::host_reqs_t rq = '0;
    host_port_pkg::core_irqs_t irq_o;
    host_port_pkg::host_strobes_t stb_o;
    int miscompares = 0, tests_run = 0, cycles = 0, ctrl_m = 0, cfg_m = 0, i;
    always #10 clk_i = ~clk_i;
    host_port_ctrl host_port_ctrl_i (.clk_i, .rst_i, .ce_i(1'b1), .soft_rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .wb_err_o(err_o),
        .events_i(ev), .reqs_i(rq), .double_request_select_i(drq), .irqs_o(irq_o),
        .core_flag_2_o(f2), .core_flag_3_o(f3), .dma_mode_o(mode_o), .dma_enable_o(dma_en),
        .dma_core_to_host_o(c2h), .dma_width_o(width_o), .muxed_bus_o(mux_o),
        .dual_strobe_o(dual_o), .port_enable_o(port_o), .strobes_o(stb_o), .pin_i,
        .pin_o, .pin_oe_o(oe_o), .host_fn_o(fn_o), .gpio_out_i(gout), .gpio_dir_i(gdir),
        .gpio_in_o(gin_o));
    host_bus_model host_bus_model_i (.dual_i(cfg_m[12]), .strobe_pol_i(cfg_m[9]),
        .as_pol_i(cfg_m[10]), .select_pol_i(cfg_m[13]), .ack_pol_i(cfg_m[15]), .drq_i(drq),
        .act_i(act), .addr_i(addr), .pin_o, .pin_oe_o(oe_o), .pin_i);
    // =====================================
    // bus cycle, entered just after an edge
    task automatic wb(input logic w, input logic [3:0] a, input int d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(ack_o || err_o) && n < 50);
        rdat = dat_o;
        errb = err_o;
        if (n == 50) begin
            miscompares++;
            close_out();
        end
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic check_pins();
        logic en, mx;
        logic [4:0] fn;
        en = cfg_m[6];
        mx = cfg_m[11];
        fn[0] = en && (cfg_m[1] || !mx);
        fn[1] = en && (cfg_m[2] || !mx);
        fn[2] = en && cfg_m[3];
        fn[3] = en && cfg_m[4];
        fn[4] = fn[3] && (cfg_m[5] || drq);
        `CHK("host fn", fn, fn_o[4:0])
        `CHK("port", {en, en && mx, en && cfg_m[12]}, {port_o, mux_o, dual_o})
        for (int k = 0; k < 5; k++)
            if (!fn[k]) begin
                `CHK("gpio oe", cfg_m[0] && gdir[k], oe_o[k])
                `CHK("gpio in", cfg_m[0] ? pin_i[k] : 1'b0, gin_o[k])
            end
        if (fn[3]) begin
            `CHK("req pin", (drq ? rq.tx_req : rq.host_req) ~^ cfg_m[14], pin_i[3])
            `CHK("req oe", !cfg_m[8] || !pin_i[3], oe_o[3])
        end
        if (fn[4] && drq)
            `CHK("rx req pin", rq.rx_req ~^ cfg_m[14], pin_i[4])
        if (fn[4] && !drq)
            `CHK("ack", act[0], stb_o.acknowledge)
        if (fn[2])
            `CHK("select", act[4], stb_o.select)
        if (en) begin
            `CHK("as", act[3] && mx, stb_o.addr_strobe)
            if (cfg_m[12])
                `CHK("rd wr", act[2:1], {stb_o.read_strobe, stb_o.write_strobe})
            else
                `CHK("ds", act[2] | act[1], stb_o.data_strobe)
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // limit well above the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        seed_v = $urandom(74);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ctrl_a, 0);
        `CHK("ctrl reset", 32'h0, rdat)
        wb(1'b0, cfg_a, 0);
        `CHK("cfg reset", 32'h0, rdat)
        wb(1'b1, 4'h2, 32'hff);
        `CHK("unmapped", 1'b1, errb)
        for (i = 0; i < 8; i++) begin
            ctrl_m = {i[2:0], 5'($urandom)};
            wb(1'b1, ctrl_a, ctrl_m);
            wb(1'b0, ctrl_a, 0);
            `CHK("ctrl rd", ctrl_m, rdat)
            `CHK("mode", i[2:0], mode_o)
            `CHK("dma en", i != 0, dma_en)
            `CHK("c2h", i > 4, c2h)
            `CHK("width", i[1:0], width_o)
            `CHK("flags", ctrl_m[4:3], {f3, f2})
        end
        for (i = 0; i < 8; i++) begin
            ctrl_m = $urandom & 32'h7;
            wb(1'b1, ctrl_a, ctrl_m);
            ev <= 3'($urandom);
            repeat (2) @(posedge clk_i);
            `CHK("irqs", {ctrl_m[0], ctrl_m[1], ctrl_m[2]} & ev, irq_o)
        end
        wb(1'b1, ctrl_a, 32'hff);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, ctrl_a, 0);
        `CHK("soft rst", 32'h0, rdat)
        for (i = 0; i < 40; i++) begin
            cfg_m = $urandom & 32'hff7f;
            if (i[1:0] != 2'h0) cfg_m[6] = 1'b1;
            drq <= i[2];
            gdir <= 8'($urandom);
            gout <= 8'($urandom);
            rq <= 3'($urandom);
            act <= 5'($urandom);
            addr <= 2'($urandom);
            wb(1'b1, cfg_a, cfg_m);
            wb(1'b0, cfg_a, 0);
            `CHK("cfg rd", cfg_m, rdat)
            // pins pass two sync stages and a strobe register
            repeat (4) @(posedge clk_i);
            check_pins();
        end
        close_out();
    end
endmodule
